/* prpb_pkg.sv */
package prpb_pkg;
	// ==========================================
	// Data types
	localparam logic [5:0] DT_ACK_ERR = 6'h02;
	localparam logic [5:0] DT_EOTP = 6'h08;
	localparam logic [5:0] DT_GEN_SHORT1 = 6'h11;
	localparam logic [5:0] DT_GEN_SHORT2 = 6'h12;
	localparam logic [5:0] DT_GEN_LONG = 6'h1a;
	localparam logic [5:0] DT_DCS_LONG = 6'h1c;
	localparam logic [5:0] DT_DCS_SHORT1 = 6'h21;
	localparam logic [5:0] DT_DCS_SHORT2 = 6'h22;
	// ==========================================
	// Trigger and fixed fields
	localparam logic [7:0] ACK_TRIGGER = 8'h84;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	localparam logic [15:0] NO_CHECKSUM = 16'h0000;
	localparam logic [1:0] ACK_VC = 2'h0;
	localparam int DI_VC_MSB = 7;
	localparam int DI_VC_LSB = 6;
	// ==========================================
	// Error report bit positions
	localparam int ERR_SOT = 0;
	localparam int ERR_SOT_SYNC = 1;
	localparam int ERR_EOT_SYNC = 2;
	localparam int ERR_ESC_ENTRY = 3;
	localparam int ERR_LP_SYNC = 4;
	localparam int ERR_HS_TIMEOUT = 5;
	localparam int ERR_FALSE_CTRL = 6;
	localparam int ERR_ECC_SINGLE = 8;
	localparam int ERR_ECC_MULTI = 9;
	localparam int ERR_CHECKSUM = 10;
	localparam int ERR_DT_UNKNOWN = 11;
	localparam int ERR_VC_INVALID = 12;
	localparam int ERR_LENGTH = 13;
	localparam int ERR_PROTOCOL = 15;
	localparam logic [15:0] ERR_RESERVED_MASK = 16'h4080;
	localparam logic [15:0] ERR_RESET = 16'h0000;
	// ==========================================
	// Sizes
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [6:0] PROTO_RESET = 7'h00;
	// ==========================================
	// Response kinds
	typedef enum logic [2:0] {
		PRPB_RSP_ACK = 3'b000,
		PRPB_RSP_SHORT1 = 3'b001,
		PRPB_RSP_SHORT2 = 3'b010,
		PRPB_RSP_LONG = 3'b011,
		PRPB_RSP_ERR = 3'b100
	} prpb_rsp_t;
endpackage

/* prpb_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module prpb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// ==========================================
	// Storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// ==========================================
	// Pointers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* prpb_ecc.sv */
`timescale 1ns/10ps
`default_nettype none
module prpb_ecc (
	input wire logic [23:0] hdr,
	output logic [7:0] ecc
);
	// Hamming parity over the 24 header bits, top two bits zero
	always_comb begin
		ecc = 8'h00;
		ecc[0] = ^(hdr & 24'hf12cb7);
		ecc[1] = ^(hdr & 24'hf2555b);
		ecc[2] = ^(hdr & 24'h749a6d);
		ecc[3] = ^(hdr & 24'hb8e38e);
		ecc[4] = ^(hdr & 24'hdf03f0);
		ecc[5] = ^(hdr & 24'heffc00);
	end
endmodule
`default_nettype wire

/* prpb_builder.sv */
`timescale 1ns/10ps
`default_nettype none
module prpb_builder
	import prpb_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic [15:0] err_event,
	input wire logic rx_abort,
	input wire logic [6:0] proto_detail,
	output logic [15:0] err_bits,
	output logic [6:0] proto_status,
	output logic drop_active,
	input wire logic rx_end,
	input wire logic rsp_start,
	input wire logic [2:0] rsp_kind,
	input wire logic rsp_dcs,
	input wire logic [1:0] rsp_vc,
	input wire logic [15:0] rsp_data,
	input wire logic [15:0] rsp_wc,
	input wire logic csum_enable,
	input wire logic [15:0] rsp_csum,
	input wire logic eot_append,
	input wire logic [7:0] pay_data,
	input wire logic pay_valid,
	output logic pay_ready,
	output logic busy,
	output logic done,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic tx_trigger,
	output logic tx_lastbit
);
	import prpb_pkg::*;

	typedef enum logic [2:0] {
		PRPB_IDLE = 3'b000,
		PRPB_HDR = 3'b001,
		PRPB_PAY = 3'b010,
		PRPB_CSUM = 3'b011,
		PRPB_ERR = 3'b100,
		PRPB_EOT = 3'b101
	} prpb_state_t;

	prpb_state_t state_reg;
	logic [15:0] err_reg;
	logic [6:0] proto_reg;
	logic drop_reg;
	logic [2:0] lk_sync_reg;
	logic lk_edge;
	logic [1:0] idx_reg;
	logic [15:0] cnt_reg;
	logic proto_keep;
	logic [15:0] csum_reg;
	logic [15:0] snap_reg;
	logic send_err_reg;
	logic eot_reg;
	logic [7:0] ecc_calc;
	logic [23:0] hdr_body;
	logic [7:0] byte_sel;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [7:0] fifo_in_data;
	logic trig_reg;
	logic last_reg;
	logic done_reg;
	logic tx_fire;
	logic [5:0] dt_sel;
	logic [15:0] report_clear;

	// ==========================================
	// Link clock sampling, rising edge when stage 2 is high and stage 3 still low
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lk_sync_reg <= 3'h0;
		end else begin
			lk_sync_reg <= {lk_sync_reg[1:0], link_clk};
		end
	end
	assign lk_edge = lk_sync_reg[1] && !lk_sync_reg[2];

	// ==========================================
	// Error register
	assign report_clear = (state_reg == PRPB_ERR && tx_fire && idx_reg == 2'h3) ?
		snap_reg : 16'h0000;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			err_reg <= ERR_RESET;
		end else begin
			// Clear only what was reported, new events win
			err_reg <= (err_reg & ~report_clear) | (err_event & ~ERR_RESERVED_MASK);
		end
	end
	assign err_bits = err_reg;

	// Protocol violation details, read as a status port
	// Details stay readable after the report
	// A new violation after a report starts a fresh set
	assign proto_keep = err_reg[ERR_PROTOCOL] && !report_clear[ERR_PROTOCOL];
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			proto_reg <= PROTO_RESET;
		end else if (err_event[ERR_PROTOCOL]) begin
			proto_reg <= (proto_keep ? proto_reg : PROTO_RESET) | proto_detail;
		end
	end
	assign proto_status = proto_reg;

	// Drop remainder of transmission after fatal receive error
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			drop_reg <= 1'b0;
		end else if (err_event[ERR_DT_UNKNOWN] || err_event[ERR_ECC_MULTI] || rx_abort) begin
			drop_reg <= 1'b1;
		end else if (rx_end) begin
			drop_reg <= 1'b0;
		end
	end
	assign drop_active = drop_reg;

	// ==========================================
	// Header assembly
	always_comb begin
		dt_sel = DT_ACK_ERR;
		case (rsp_kind)
			PRPB_RSP_SHORT1: dt_sel = rsp_dcs ? DT_DCS_SHORT1 : DT_GEN_SHORT1;
			PRPB_RSP_SHORT2: dt_sel = rsp_dcs ? DT_DCS_SHORT2 : DT_GEN_SHORT2;
			PRPB_RSP_LONG: dt_sel = rsp_dcs ? DT_DCS_LONG : DT_GEN_LONG;
			default: dt_sel = DT_ACK_ERR;
		endcase
	end

	prpb_ecc u_ecc (
		.hdr(hdr_body),
		.ecc(ecc_calc)
	);

	// ==========================================
	// Sequencer
	assign tx_fire = fifo_in_valid && fifo_in_ready;
	assign busy = (state_reg != PRPB_IDLE);
	assign pay_ready = (state_reg == PRPB_PAY) && fifo_in_ready && (cnt_reg != 16'h0);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= PRPB_IDLE;
			idx_reg <= 2'h0;
			cnt_reg <= 16'h0;
			hdr_body <= 24'h0;
			csum_reg <= NO_CHECKSUM;
			snap_reg <= 16'h0;
			send_err_reg <= 1'b0;
			eot_reg <= 1'b0;
			trig_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			trig_reg <= 1'b0;
			case (state_reg)
				PRPB_IDLE: begin
					idx_reg <= 2'h0;
					eot_reg <= eot_append;
					if (rsp_start) begin
						// Pending errors follow read data, or replace the acknowledge
						send_err_reg <= (err_reg != 16'h0) && (rsp_kind != PRPB_RSP_ERR);
						if (err_reg == 16'h0 && rsp_kind == PRPB_RSP_ACK) begin
							trig_reg <= 1'b1;
							done_reg <= 1'b1;
						end else if (rsp_kind == PRPB_RSP_ACK || rsp_kind == PRPB_RSP_ERR) begin
							snap_reg <= err_reg;
							hdr_body <= {err_reg[15:8], err_reg[7:0], ACK_VC, DT_ACK_ERR};
							state_reg <= PRPB_ERR;
						end else begin
							hdr_body[7:0] <= {rsp_vc, dt_sel};
							if (rsp_kind == PRPB_RSP_LONG) begin
								hdr_body[23:8] <= {rsp_wc[15:8], rsp_wc[7:0]};
								cnt_reg <= rsp_wc;
							end else if (rsp_kind == PRPB_RSP_SHORT1) begin
								hdr_body[23:8] <= {PAD_BYTE, rsp_data[7:0]};
							end else begin
								hdr_body[23:8] <= rsp_data;
							end
							csum_reg <= csum_enable ? rsp_csum : NO_CHECKSUM;
							state_reg <= PRPB_HDR;
						end
					end
				end
				PRPB_HDR: begin
					if (tx_fire) begin
						idx_reg <= idx_reg + 2'h1;
						if (idx_reg == 2'h3) begin
							if (hdr_body[5:0] == DT_GEN_LONG || hdr_body[5:0] == DT_DCS_LONG) begin
								state_reg <= PRPB_PAY;
							end else if (send_err_reg) begin
								snap_reg <= err_reg;
								hdr_body <= {err_reg[15:8], err_reg[7:0], ACK_VC, DT_ACK_ERR};
								state_reg <= PRPB_ERR;
							end else begin
								state_reg <= eot_reg ? PRPB_EOT : PRPB_IDLE;
								done_reg <= !eot_reg;
							end
						end
					end
				end
				PRPB_PAY: begin
					if (cnt_reg == 16'h0) begin
						state_reg <= PRPB_CSUM;
						idx_reg <= 2'h0;
					end else if (tx_fire) begin
						cnt_reg <= cnt_reg - 16'h1;
					end
				end
				PRPB_CSUM: begin
					if (tx_fire) begin
						idx_reg <= idx_reg + 2'h1;
						if (idx_reg == 2'h1) begin
							idx_reg <= 2'h0;
							if (send_err_reg) begin
								snap_reg <= err_reg;
								hdr_body <= {err_reg[15:8], err_reg[7:0], ACK_VC, DT_ACK_ERR};
								state_reg <= PRPB_ERR;
							end else begin
								state_reg <= eot_reg ? PRPB_EOT : PRPB_IDLE;
								done_reg <= !eot_reg;
							end
						end
					end
				end
				PRPB_ERR: begin
					if (tx_fire) begin
						idx_reg <= idx_reg + 2'h1;
						if (idx_reg == 2'h3) begin
							send_err_reg <= 1'b0;
							state_reg <= eot_reg ? PRPB_EOT : PRPB_IDLE;
							done_reg <= !eot_reg;
						end
					end
				end
				PRPB_EOT: begin
					if (hdr_body[5:0] != DT_EOTP) begin
						// Load end packet header before its first byte
						hdr_body <= {16'h0f0f, ACK_VC, DT_EOTP};
					end else if (tx_fire) begin
						idx_reg <= idx_reg + 2'h1;
						if (idx_reg == 2'h3) begin
							state_reg <= PRPB_IDLE;
							done_reg <= 1'b1;
						end
					end
				end
				default: state_reg <= PRPB_IDLE;
			endcase
		end
	end

	// ==========================================
	// Byte selection into the FIFO
	always_comb begin
		byte_sel = 8'h00;
		fifo_in_valid = 1'b0;
		case (state_reg)
			PRPB_HDR, PRPB_ERR, PRPB_EOT: begin
				fifo_in_valid = !(state_reg == PRPB_EOT && idx_reg == 2'h0 && hdr_body[5:0] != DT_EOTP);
				case (idx_reg)
					2'h0: byte_sel = hdr_body[7:0];
					2'h1: byte_sel = hdr_body[15:8];
					2'h2: byte_sel = hdr_body[23:16];
					default: byte_sel = ecc_calc;
				endcase
			end
			PRPB_PAY: begin
				fifo_in_valid = pay_valid && (cnt_reg != 16'h0);
				byte_sel = pay_data;
			end
			PRPB_CSUM: begin
				fifo_in_valid = 1'b1;
				byte_sel = (idx_reg == 2'h0) ? csum_reg[7:0] : csum_reg[15:8];
			end
			default: begin
				fifo_in_valid = 1'b0;
			end
		endcase
	end
	assign fifo_in_data = byte_sel;

	prpb_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_data(fifo_in_data),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(tx_byte),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	// ==========================================
	// Trigger and status outputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_trigger <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			tx_trigger <= trig_reg ? 1'b1 : (lk_edge ? 1'b0 : tx_trigger);
			last_reg <= lk_edge;
		end
	end
	assign tx_lastbit = last_reg;
	assign done = done_reg;
endmodule
`default_nettype wire

/* prpb_builder_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checker
module prpb_builder_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [15:0] err_event,
	input wire logic rx_abort,
	input wire logic rx_end,
	input wire logic [6:0] proto_detail,
	input wire logic [15:0] err_bits,
	input wire logic [6:0] proto_status,
	input wire logic drop_active,
	input wire logic rsp_start,
	input wire logic [2:0] rsp_kind,
	input wire logic busy,
	input wire logic pay_ready,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_trigger
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_stall; tx_valid && !tx_ready; endsequence
	sequence s_drop; rx_abort || err_event[9] || err_event[11]; endsequence
	property p_hold; s_stall |=> tx_valid && $stable(tx_byte); endproperty
	a_hold: assert property (p_hold) else $error("byte moved in stall");
	property p_set;
		(|(err_event & 16'hbf7f)) |=> (err_bits & $past(err_event)) == ($past(err_event) & 16'hbf7f);
	endproperty
	a_set: assert property (p_set) else $error("error bit not set");
	property p_resv; err_bits[7] == 1'b0 && err_bits[14] == 1'b0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bit set");
	property p_keep; !busy && !rsp_start |=> (err_bits & $past(err_bits)) == $past(err_bits); endproperty
	a_keep: assert property (p_keep) else $error("error bit lost");
	property p_drop; s_drop |=> drop_active; endproperty
	a_drop: assert property (p_drop) else $error("no drop");
	property p_dend;
		rx_end && !(rx_abort || err_event[9] || err_event[11]) |=> !drop_active;
	endproperty
	a_dend: assert property (p_dend) else $error("drop not ended");
	property p_dhold; drop_active && !rx_end |=> drop_active; endproperty
	a_dhold: assert property (p_dhold) else $error("drop ended early");
	property p_proto;
		err_event[15] |=> (proto_status & $past(proto_detail)) == $past(proto_detail);
	endproperty
	a_proto: assert property (p_proto) else $error("detail lost");
	property p_trig; $rose(tx_trigger) |-> err_bits == 16'h0000; endproperty
	a_trig: assert property (p_trig) else $error("ack with errors");
	property p_pay; pay_ready |-> busy; endproperty
	a_pay: assert property (p_pay) else $error("payload taken idle");
	property p_busy; rsp_start && !busy && rsp_kind inside {3'h1, 3'h2, 3'h3} |=> busy; endproperty
	a_busy: assert property (p_busy) else $error("read not started");
endmodule
bind prpb_builder prpb_builder_chk u_chk (.core_clk, .rst_n, .err_event, .rx_abort, .rx_end,
	.proto_detail, .err_bits, .proto_status, .drop_active, .rsp_start, .rsp_kind, .busy,
	.pay_ready, .tx_byte, .tx_valid, .tx_ready, .tx_trigger);
`default_nettype wire

/* prpb_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Host side of the reverse link
module prpb_host (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic run,
	output logic tx_ready,
	output logic link_clk
);
	initial begin
		tx_ready = 1'b1;
		link_clk = 1'b0;
	end
	// Random stalls when slow
	always @(posedge core_clk) begin
		tx_ready <= #1 !slow || ($urandom % 4 == 0);
	end
	// Link clock only within frames
	always begin
		#400;
		if (run) link_clk = !link_clk;
	end
endmodule
`default_nettype wire

/* tb_prpb_builder.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("BAD %0t got %h exp %h", $time, a, b); end end
// ==========
// Bench
module tb_prpb_builder;
	import prpb_pkg::*;
	logic core_clk = 0, rst_n = 0, rx_abort = 0, rx_end = 0, rsp_start = 0, rsp_dcs = 0;
	logic csum_enable = 0, eot_append = 0, pay_valid = 0, slow = 0, run = 0;
	logic [15:0] err_event = 0, rsp_data = 0, rsp_wc = 0, rsp_csum = 0;
	logic [6:0] proto_detail = 0;
	logic [2:0] rsp_kind = 0;
	logic [1:0] rsp_vc = 0;
	logic [7:0] pay_data = 0;
	logic [15:0] err_bits;
	logic [6:0] proto_status;
	logic [7:0] tx_byte;
	logic link_clk, drop_active, pay_ready, busy, done, tx_valid, tx_ready, tx_trigger, tx_lastbit;
	int i, j, k, e, m_err = 0, m_proto = 0, failures = 0, samples_checked = 0;
	int exp_q[$];
	prpb_builder dut (.core_clk, .rst_n, .link_clk, .err_event, .rx_abort, .proto_detail,
		.err_bits, .proto_status, .drop_active, .rx_end, .rsp_start, .rsp_kind, .rsp_dcs,
		.rsp_vc, .rsp_data, .rsp_wc, .csum_enable, .rsp_csum, .eot_append, .pay_data,
		.pay_valid, .pay_ready, .busy, .done, .tx_byte, .tx_valid, .tx_ready, .tx_trigger,
		.tx_lastbit);
	prpb_host host (.core_clk, .slow, .run, .tx_ready, .link_clk);
	always #50 core_clk = !core_clk;
	always @(posedge core_clk) begin
		if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : -9;
			if (e >= 0) `CHK(tx_byte, e[7:0])
			else if (e == -2) `CHK(tx_byte[5:0], 6'h08)
			else if (e == -1) `CHK(tx_byte[7:6], 2'b00)
			else `CHK(1'b0, 1'b1)
		end
	end
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic push16(logic [15:0] v);
		exp_q.push_back(v[7:0]);
		exp_q.push_back(v[15:8]);
	endtask
	task automatic ev(logic [15:0] v);
		err_event = v;
		proto_detail = 7'($urandom);
		if (v[15]) m_proto = (m_err[15] ? m_proto : 0) | proto_detail;
		m_err |= v & 16'hbf7f;
		tick(1);
		err_event = '0;
	endtask
	task automatic req(int k, int n);
		int i;
		logic [7:0] dt;
		rsp_kind = k[2:0];
		rsp_dcs = 1'($urandom);
		rsp_vc = 2'($urandom);
		rsp_data = 16'($urandom);
		rsp_wc = n[15:0];
		csum_enable = 1'($urandom);
		rsp_csum = 16'($urandom);
		eot_append = k != 0 && $urandom % 2;
		dt = (rsp_dcs ? 8'h20 : 8'h10) + k[7:0];
		if (k == 3) dt = rsp_dcs ? 8'h1c : 8'h1a;
		if (k inside {[1:3]}) begin
			exp_q.push_back({rsp_vc, dt[5:0]});
			push16(k == 3 ? rsp_wc : k == 1 ? {8'h00, rsp_data[7:0]} : rsp_data);
			exp_q.push_back(-1);
		end
		rsp_start = 1'b1;
		tick(1);
		rsp_start = 1'b0;
		for (i = 0; i < n; i++) begin
			pay_valid = 1'b1;
			pay_data = 8'($urandom);
			exp_q.push_back(pay_data);
			@(negedge core_clk);
			while (pay_ready !== 1'b1) @(negedge core_clk);
			tick(1);
		end
		pay_valid = 1'b0;
		if (k == 3) push16(csum_enable ? rsp_csum : 16'h0000);
		i = 0;
		if (k == 0 && m_err == 0) begin
			tick(1);
			`CHK(tx_trigger, 1'b1)
			run = 1'b1;
			while (tx_trigger === 1'b1 && i < 100) begin
				tick(1);
				i++;
			end
			run = 1'b0;
			`CHK(tx_trigger, 1'b0)
			`CHK(tx_lastbit, 1'b1)
		end else begin
			if (m_err != 0) begin
				exp_q.push_back(8'h02);
				push16(m_err[15:0]);
				exp_q.push_back(-1);
				m_err = 0;
			end
			if (eot_append) exp_q.push_back(-2);
			if (eot_append) push16(16'h0f0f);
			if (eot_append) exp_q.push_back(-1);
			while (done !== 1'b1 && i < 500) begin
				@(negedge core_clk);
				i++;
			end
			`CHK(done, 1'b1)
		end
		i = 0;
		while (exp_q.size() != 0 && i < 3000) begin
			@(negedge core_clk);
			i++;
		end
		tick(2);
		`CHK(exp_q.size(), 0)
		`CHK(err_bits, m_err[15:0])
	endtask
	task automatic summarize();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#3000000;
		failures++;
		summarize();
	end
	initial begin
		i = $urandom(2);
		tick(4);
		rst_n = 1'b1;
		`CHK({tx_valid, tx_trigger, err_bits}, 18'h0)
		`CHK(ACK_TRIGGER, 8'h84)
		for (j = 0; j < 16; j++) begin
			ev(16'h1 << j);
			rx_end = 1'b1;
			`CHK(err_bits, m_err[15:0])
			tick(1);
			rx_end = 1'b0;
		end
		`CHK(proto_status, m_proto[6:0])
		rx_abort = 1'b1;
		tick(1);
		rx_abort = 1'b0;
		tick(3);
		`CHK(drop_active, 1'b1)
		rx_end = 1'b1;
		tick(1);
		rx_end = 1'b0;
		`CHK(drop_active, 1'b0)
		req(4, 0);
		req(0, 0);
		slow = 1'b1;
		req(3, 40);
		for (j = 0; j < 30; j++) begin
			slow = 1'($urandom);
			if ($urandom % 3 == 0) ev(16'($urandom));
			k = $urandom % 5;
			if (k == 4 && m_err == 0) k = 2;
			req(k, k == 3 ? $urandom % 36 : 0);
		end
		`CHK(proto_status, m_proto[6:0])
		summarize();
	end
endmodule
`default_nettype wire
